/* hdl/sdcl_pkg.sv */
// Constants and carrier types for the synthesizer divider config loader.
// Assumes one 20 MHz bus clock; all pin inputs synchronous to it.
package sdcl_pkg;
  // ----------------------------------------------------------------
  // Serial shift register layout
  // ----------------------------------------------------------------
  localparam int SHIFT_W = 14;
  localparam int T_HI = 13;
  localparam int T_LO = 11;
  localparam int N_HI = 10;
  localparam int N_LO = 9;
  localparam int M_HI = 8;
  localparam int M_LO = 0;
  localparam int M_W = 9;
  localparam int N_W = 2;
  localparam int T_W = 3;
  // ----------------------------------------------------------------
  // Test select codes
  // ----------------------------------------------------------------
  localparam logic [2:0] TS_SHIFT = 3'h0;
  localparam logic [2:0] TS_HIGH = 3'h1;
  localparam logic [2:0] TS_REF = 3'h2;
  localparam logic [2:0] TS_LOOP = 3'h3;
  localparam logic [2:0] TS_SYNTH = 3'h4;
  localparam logic [2:0] TS_LOW = 3'h5;
  localparam logic [2:0] TS_BYPASS = 3'h6;
  localparam logic [2:0] TS_SYNTH4 = 3'h7;
  // ----------------------------------------------------------------
  // Dividers and reset values
  // ----------------------------------------------------------------
  localparam int REF_DIV = 16;
  localparam logic [3:0] BYPASS_MIN_RATIO = 4'h2;
  localparam logic [M_W-1:0] M_RESET = 9'h1_FF;
  localparam logic [N_W-1:0] N_RESET = 2'h3;
  // ----------------------------------------------------------------
  // Register map (byte addresses) and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_SHIFT = 8'h08;
  localparam int CTRL_OE = 0;
  localparam int ST_M_LO = 0;
  localparam int ST_N_LO = 12;
  localparam int ST_T_LO = 16;
  localparam int ST_BYP = 20;
  localparam logic CTRL_RESET = 1'b1;

  typedef struct packed {
    logic [T_W-1:0] tsel;
    logic [N_W-1:0] ndiv;
    logic [M_W-1:0] mdiv;
  } sdcl_cfg_t;

  typedef struct packed {
    logic shift_clk;
    logic shift_data;
    logic serial_latch;
    logic par_latch;
  } sdcl_pins_t;
endpackage

/* hdl/sdcl_loader.sv */
// Divider configuration loader with serial/parallel ports and test mux.
// Assumes AHB-Lite single master, all pins synchronous to hclk.
//
// What this block does
// - Serial bits enter a 14-bit shift register, one step per rising shift clock edge while parallel strobe is high.
// - Stream order: test select, then output divider, then loop divider.
// - Each field arrives most significant bit first.
// - Falling serial latch moves shifted dividers into the counters.
// - Test select is loaded from data only through the serial port.
// - Parallel strobe low forces test select to zero.
// - Test select 110 selects bypass; divider path ignores the loop source.
// - In bypass the shift clock steps both dividers directly.
// - Bypass: output divider drives output pair, loop divider drives debug.
// - Output divider ratio is at least 2 in bypass.
// - Loop divider pulse on debug pin need not be 50% duty.
// - Code 000 shows shift register out; code 001 drives debug high.
// - Code 010 shows divided reference; code 011 loop divider output.
// - Rising parallel strobe loads loop and output divider inputs.
// - Serial data is sampled on the rising shift clock edge.
// - Serial latches are transparent while serial latch strobe is high.
`timescale 1ns/1ps
module sdcl_loader
  import sdcl_pkg::*;
#(
  parameter int REF_RATIO = REF_DIV
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Configuration pins
  input wire sdcl_pins_t pins,
  input wire logic [M_W-1:0] par_m,
  input wire logic [N_W-1:0] par_n,
  // Loop oscillator edge events (one-cycle pulse per edge)
  input wire logic loop_tick,
  // Outputs
  output logic synth_out_pair_p,
  output logic synth_out_pair_n,
  output logic debug_out
);

  // ----------------------------------------------------------------
  // Pin edge detection
  // ----------------------------------------------------------------
  logic sclk_q;
  logic sload_q;
  logic sclk_rise;
  logic sclk_edge;
  logic sload_fall;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sclk_q <= 1'b0;
      sload_q <= 1'b0;
    end else begin
      sclk_q <= pins.shift_clk;
      sload_q <= pins.serial_latch;
    end
  end

  assign sclk_rise = pins.shift_clk && !sclk_q;
  assign sclk_edge = pins.shift_clk != sclk_q;
  assign sload_fall = !pins.serial_latch && sload_q;

  // ----------------------------------------------------------------
  // Shift register
  // ----------------------------------------------------------------
  logic [SHIFT_W-1:0] shift_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shift_q <= '0;
    end else if (sclk_rise && pins.par_latch) begin
      shift_q <= {shift_q[SHIFT_W-2:0], pins.shift_data};
    end
  end

  // ----------------------------------------------------------------
  // Configuration latches
  // ----------------------------------------------------------------
  sdcl_cfg_t cfg_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_q <= '{tsel: TS_SHIFT, ndiv: N_RESET, mdiv: M_RESET};
    end else if (!pins.par_latch) begin
      // Transparent while low, held from the rising edge
      cfg_q.mdiv <= par_m;
      cfg_q.ndiv <= par_n;
      cfg_q.tsel <= TS_SHIFT;
    end else if (pins.serial_latch) begin
      // Transparent while high; fall keeps last value
      // Only the serial path loads tsel from data; the parallel path forces zero
      cfg_q.tsel <= shift_q[T_HI:T_LO];
      cfg_q.ndiv <= shift_q[N_HI:N_LO];
      cfg_q.mdiv <= shift_q[M_HI:M_LO];
    end
  end

  // ----------------------------------------------------------------
  // Divider path
  // ----------------------------------------------------------------
  logic bypass;
  logic div_tick;
  logic [3:0] ratio;
  logic [3:0] out_cnt_q;
  logic synth_q;
  logic [1:0] synth4_q;
  logic [M_W-1:0] loop_cnt_q;
  logic loop_out_q;

  assign bypass = cfg_q.tsel == TS_BYPASS;
  assign div_tick = bypass ? sclk_edge : loop_tick;

  always_comb begin
    ratio = 4'h1 << cfg_q.ndiv;
    if (bypass && ratio < BYPASS_MIN_RATIO) begin
      ratio = BYPASS_MIN_RATIO;
    end
  end

  // Output pair toggles once every ratio source edges
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_cnt_q <= 4'h0;
      synth_q <= 1'b0;
    end else if (div_tick) begin
      if (out_cnt_q + 4'h1 >= ratio) begin
        out_cnt_q <= 4'h0;
        synth_q <= !synth_q;
      end else begin
        out_cnt_q <= out_cnt_q + 4'h1;
      end
    end
  end

  logic synth_out_pair_p_raw_q;

  // Quarter-rate copy of the output for the debug mux
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      synth4_q <= 2'h0;
    end else if (synth_q && !synth_out_pair_p_raw_q) begin
      synth4_q <= synth4_q + 2'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      synth_out_pair_p_raw_q <= 1'b0;
    end else begin
      synth_out_pair_p_raw_q <= synth_q;
    end
  end

  // One-edge pulse per M edges; duty is not balanced
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      loop_cnt_q <= '0;
      loop_out_q <= 1'b0;
    end else if (div_tick) begin
      if (loop_cnt_q + 9'h001 >= cfg_q.mdiv) begin
        loop_cnt_q <= '0;
        loop_out_q <= 1'b1;
      end else begin
        loop_cnt_q <= loop_cnt_q + 9'h001;
        loop_out_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Reference divider
  // ----------------------------------------------------------------
  localparam int REF_HALF = REF_RATIO / 2;
  logic [7:0] ref_cnt_q;
  logic ref_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_cnt_q <= 8'h00;
      ref_q <= 1'b0;
    end else if (ref_cnt_q == 8'(REF_HALF - 1)) begin
      ref_cnt_q <= 8'h00;
      ref_q <= !ref_q;
    end else begin
      ref_cnt_q <= ref_cnt_q + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Register interface
  // ----------------------------------------------------------------
  logic ctrl_oe_q;
  logic wr_pend_q;
  logic [7:0] addr_q;
  logic take;

  assign take = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      addr_q <= 8'h00;
    end else begin
      wr_pend_q <= take && hwrite;
      if (take) begin
        addr_q <= haddr[7:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_oe_q <= CTRL_RESET;
    end else if (wr_pend_q && addr_q == REG_CTRL) begin
      ctrl_oe_q <= hwdata[CTRL_OE];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      hrdata <= 32'h0000_0000;
      case (haddr[7:0])
        REG_CTRL: hrdata[CTRL_OE] <= ctrl_oe_q;
        REG_STATUS: begin
          hrdata[ST_M_LO +: M_W] <= cfg_q.mdiv;
          hrdata[ST_N_LO +: N_W] <= cfg_q.ndiv;
          hrdata[ST_T_LO +: T_W] <= cfg_q.tsel;
          hrdata[ST_BYP] <= bypass;
        end
        REG_SHIFT: hrdata[SHIFT_W-1:0] <= shift_q;
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Outputs and debug mux
  // ----------------------------------------------------------------
  // Enable only while output is low, avoiding runt pulses
  logic oe_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      oe_q <= 1'b0;
    end else if (!synth_q) begin
      oe_q <= ctrl_oe_q;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      synth_out_pair_p <= 1'b0;
      synth_out_pair_n <= 1'b1;
    end else begin
      synth_out_pair_p <= synth_q && oe_q;
      synth_out_pair_n <= !(synth_q && oe_q);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      debug_out <= 1'b0;
    end else begin
      case (cfg_q.tsel)
        TS_SHIFT: debug_out <= shift_q[SHIFT_W-1];
        TS_HIGH: debug_out <= 1'b1;
        TS_REF: debug_out <= ref_q;
        TS_LOOP: debug_out <= loop_out_q;
        TS_SYNTH: debug_out <= synth_q;
        TS_LOW: debug_out <= 1'b0;
        // Loop divider on debug in bypass
        TS_BYPASS: debug_out <= loop_out_q;
        TS_SYNTH4: debug_out <= synth4_q[1];
        default: debug_out <= 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  shift_step_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (sclk_rise && pins.par_latch) |=>
      shift_q == {$past(shift_q[SHIFT_W-2:0]), $past(pins.shift_data)})
    else $error("Shift register did not advance on shift edge");

  par_block_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !pins.par_latch |=> $stable(shift_q))
    else $error("Shift register moved while parallel strobe low");

  test_force_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !pins.par_latch |=> cfg_q.tsel == TS_SHIFT)
    else $error("Test select not forced to zero");

  serial_latch_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (sload_fall && pins.par_latch && $past(pins.par_latch)) |->
      cfg_q.mdiv == $past(shift_q[M_HI:M_LO], 1) ##1 $stable(cfg_q.mdiv))
    else $error("Loop divider not latched on falling serial strobe");

  par_load_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !pins.par_latch ##1 pins.par_latch |->
      cfg_q.mdiv == $past(par_m, 1) && cfg_q.ndiv == $past(par_n, 1))
    else $error("Parallel inputs not captured on rising strobe");

  serial_thru_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (pins.serial_latch && pins.par_latch) |=>
      cfg_q.tsel == $past(shift_q[T_HI:T_LO]))
    else $error("Serial latch not transparent");

  bypass_edge_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ($past(bypass) && $changed(synth_q)) |-> $past(sclk_edge))
    else $error("Bypass output moved without shift clock edge");

  bypass_ratio_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (bypass && $stable(bypass) && div_tick && $changed(synth_q)) |=>
      $stable(synth_q))
    else $error("Bypass output toggled on consecutive edges");

  debug_high_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    cfg_q.tsel == TS_HIGH |=> debug_out)
    else $error("Debug pin not high for code 001");
endmodule

/* test/sdcl_host_model.sv */
// Host controller model driving the serial and parallel config pins.
// Assumes the bench clock; pins change just after rising hclk edges.
`timescale 1ns/1ps
module sdcl_host_model
  import sdcl_pkg::*;
(
  // Clock
  input wire logic hclk,
  // Pins toward the loader
  output sdcl_pins_t pins,
  output logic [M_W-1:0] par_m,
  output logic [N_W-1:0] par_n
);
  // Power-up: parallel strobe low, as a host holds it at reset
  initial begin
    pins = '0;
    par_m = M_RESET;
    par_n = N_RESET;
  end

  task automatic tick(input int k);
    repeat (k) @(posedge hclk);
  endtask

  task automatic shift_word(input sdcl_cfg_t w);
    for (int i = SHIFT_W - 1; i >= 0; i--) begin
      pins.shift_data <= w[i];
      tick(2);
      pins.shift_clk <= 1'b1;
      tick(2);
      pins.shift_clk <= 1'b0;
      tick(2);
    end
    pins.serial_latch <= 1'b1;
    tick(2);
    pins.serial_latch <= 1'b0;
    // Idle data shows inverse so a stale value is never mistaken
    pins.shift_data <= ~w[0];
    tick(2);
  endtask

  task automatic par_load(input logic [M_W-1:0] m, input logic [N_W-1:0] n);
    pins.par_latch <= 1'b0;
    par_m <= m;
    par_n <= n;
    tick(3);
    pins.par_latch <= 1'b1;
    tick(2);
  endtask

  task automatic set_par(input logic v);
    pins.par_latch <= v;
    tick(2);
  endtask

  task automatic clk_edges(input int k);
    repeat (k) begin
      pins.shift_clk <= 1'b1;
      tick(2);
      pins.shift_clk <= 1'b0;
      tick(2);
    end
  endtask
endmodule

/* test/sdcl_loader_test.sv */
// Self-checking bench for the divider config loader.
// Assumes the host model drives the pins; bench is the AHB master.
`timescale 1ns/1ps
module sdcl_loader_test
  import sdcl_pkg::*;
;
  typedef struct packed {
    sdcl_cfg_t c;
    logic [1:0] e;
  } sdcl_row_t;
  logic hclk, hresetn, hsel, hwrite, hready, loop_tick, mon, pp, pd;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp, out_p, out_n, dbg;
  sdcl_pins_t pins;
  logic [M_W-1:0] par_m;
  logic [N_W-1:0] par_n;
  int mismatches, n_tests, cnt, cnt2;
  // Row: config, then debug expectation (bit1 set = checked)
  sdcl_row_t rows [8] = '{
    {TS_SHIFT, 2'h1, 9'h106, 2'b00}, {TS_HIGH, 2'h2, 9'h100, 2'b11},
    {TS_REF, 2'h3, 9'h0AA, 2'b00}, {TS_LOOP, 2'h0, 9'h155, 2'b00},
    {TS_SYNTH, 2'h1, 9'h1FF, 2'b00}, {TS_LOW, 2'h2, 9'h001, 2'b10},
    {TS_BYPASS, 2'h3, 9'h0C8, 2'b00}, {TS_SYNTH4, 2'h0, 9'h190, 2'b00}};

  assign hready = hreadyout;

  sdcl_loader #(.REF_RATIO(4)) u_dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pins(pins), .par_m(par_m),
    .par_n(par_n), .loop_tick(loop_tick), .synth_out_pair_p(out_p),
    .synth_out_pair_n(out_n), .debug_out(dbg));

  sdcl_host_model u_host (.hclk(hclk), .pins(pins), .par_m(par_m),
    .par_n(par_n));

  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  // Edge counters for the divider outputs
  always @(posedge hclk) begin
    pp <= out_p;
    pd <= dbg;
    if (mon) begin
      cnt += (out_p !== pp);
      cnt2 += (dbg === 1'b1 && pd === 1'b0);
    end
  end

  task finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task chk_n(input int got, input int lo, input int hi);
    n_tests++;
    if (got < lo || got > hi) begin
      mismatches++;
      $display("ERROR %0t count %0d not in %0d..%0d", $time, got, lo, hi);
    end
  endtask

  // Single AHB-Lite transfer; waits on hready under a bound
  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int i;
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    i = 0;
    do begin
      @(posedge hclk);
      i++;
    end while (hreadyout !== 1'b1 && i < 50);
    if (i >= 50) i = 100;
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do begin
      @(posedge hclk);
      i++;
    end while (hreadyout !== 1'b1 && i < 100);
    rd = hrdata;
    if (i >= 100) begin
      mismatches++;
      $display("ERROR %0t bus wait expired", $time);
      finish_test;
    end
  endtask

  function automatic logic [31:0] st(input sdcl_cfg_t c);
    logic [31:0] s;
    s = 32'h0000_0000;
    s[8:0] = c.mdiv;
    s[13:12] = c.ndiv;
    s[18:16] = c.tsel;
    s[20] = (c.tsel == TS_BYPASS);
    return s;
  endfunction

  initial begin
    #(50 * 90000);
    mismatches++;
    $display("ERROR %0t run limit reached", $time);
    finish_test;
  end

  initial begin
    {hsel, hwrite, loop_tick, mon, pp, pd} = '0;
    {haddr, hwdata, htrans, hsize} = '0;
    mismatches = 0;
    n_tests = 0;
    cnt = 0;
    cnt2 = 0;
    hresetn = 1'b0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(1'b0, REG_STATUS, 32'h0);
    chk(rd, st({TS_SHIFT, N_RESET, M_RESET}));
    ahb(1'b0, REG_CTRL, 32'h0);
    chk(rd, {31'h0, CTRL_RESET});
    ahb(1'b1, REG_CTRL, 32'h0);
    ahb(1'b0, REG_CTRL, 32'h0);
    chk(rd, 32'h0000_0000);
    ahb(1'b1, REG_CTRL, 32'h1);
    ahb(1'b1, 8'h0C, 32'hFFFF_FFFF);
    ahb(1'b0, 8'h0C, 32'h0);
    chk(rd, 32'h0000_0000);
    u_host.par_load(9'h106, 2'h1);
    ahb(1'b0, REG_STATUS, 32'h0);
    chk(rd, st({TS_SHIFT, 2'h1, 9'h106}));
    foreach (rows[k]) begin
      u_host.shift_word(rows[k].c);
      ahb(1'b0, REG_SHIFT, 32'h0);
      chk(rd, {18'h0, rows[k].c});
      ahb(1'b0, REG_STATUS, 32'h0);
      chk(rd, st(rows[k].c));
      if (rows[k].e[1])
        chk({31'h0, dbg}, {31'h0, rows[k].e[0]});
    end
    // Strobe low: test select forced, shifting refused
    u_host.set_par(1'b0);
    ahb(1'b0, REG_STATUS, 32'h0);
    chk(rd, st({TS_SHIFT, 2'h1, 9'h106}));
    u_host.shift_word({TS_HIGH, 2'h2, 9'h0F0});
    ahb(1'b0, REG_SHIFT, 32'h0);
    chk(rd, {18'h0, rows[7].c});
    u_host.par_load(9'h0C8, 2'h2);
    ahb(1'b0, REG_STATUS, 32'h0);
    chk(rd, st({TS_SHIFT, 2'h2, 9'h0C8}));
    // Bypass with output code 00 still divides by two
    u_host.shift_word({TS_BYPASS, 2'h0, 9'h004});
    mon = 1'b1;
    cnt = 0;
    cnt2 = 0;
    u_host.clk_edges(8);
    u_host.tick(6);
    mon = 1'b0;
    chk_n(cnt, 8, 8);
    chk_n(cnt2, 4, 4);
    chk({31'h0, out_n}, {31'h0, ~out_p});
    u_host.shift_word({TS_REF, 2'h1, 9'h064});
    cnt2 = 0;
    mon = 1'b1;
    u_host.tick(40);
    mon = 1'b0;
    chk_n(cnt2, 9, 11);
    // Loop source ticks every other cycle; code 011 pulses each fourth
    u_host.shift_word({TS_LOOP, 2'h0, 9'h004});
    cnt2 = 0;
    mon = 1'b1;
    repeat (20) begin
      loop_tick <= 1'b1;
      u_host.tick(1);
      loop_tick <= 1'b0;
      u_host.tick(1);
    end
    u_host.tick(4);
    mon = 1'b0;
    chk_n(cnt2, 5, 5);
    // Host steps the loop divider by a single code
    u_host.shift_word({TS_LOOP, 2'h0, 9'h005});
    ahb(1'b0, REG_STATUS, 32'h0);
    chk(rd, st({TS_LOOP, 2'h0, 9'h005}));
    // Reset in mid-run brings outputs and registers back to rest
    hresetn <= 1'b0;
    u_host.tick(2);
    chk({30'h0, out_p, out_n}, 32'h0000_0001);
    chk({31'h0, dbg}, 32'h0000_0000);
    hresetn <= 1'b1;
    u_host.tick(1);
    ahb(1'b0, REG_STATUS, 32'h0);
    chk(rd, st({TS_SHIFT, N_RESET, M_RESET}));
    ahb(1'b0, REG_CTRL, 32'h0);
    chk(rd, {31'h0, CTRL_RESET});
    finish_test;
  end
endmodule
